// *** pmwc_power_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// - wake flag bit 2: battery monitor wake enable on write, flag on read
// - wake flag bit 0: pulse counter wake enable on write, flag on read
// - cleared enable keeps that event from waking suspend or sleep
// - any flag set refuses entry into suspend or sleep
// - any flag set keeps the low power oscillator running
// - flags read zero for two clocks after suspend wake
// - mode bit 7 routes buffered rtc clock to port 0 bit 2
// - mode bit 6 enables sleep wake request on port 0 bit 3
// - mode bit 5 set disables the supply monitor
// - mode bits 4 to 0 ignore writes, read zero
// - control bits 7 to 3 are plain general purpose flags
// - control bit 2 selects battery (0) or converter output (1)
// - writing 1 to control bit 1 enters stop, write only
// - writing 1 to control bit 0 enters idle, write only
// - leaving sleep drives wake request low for other devices
// - flags update on every battery monitor and pulse counter event, enabled or not
// - clear bit 5 of wake config resets all flags
// - with monitor off, any reset source gives a full power-on reset
module pmwc_power_ctrl (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // register port
  input  wire pmwc_pkg::pmwc_bus_t  bus_req,
  output logic [7:0]                bus_rdata,
  // wake event pins
  input  wire pmwc_pkg::pmwc_events_t event_pins,
  // reset pin falling edge and pending interrupt
  input  wire logic                 reset_pin_wake,
  input  wire logic                 irq_pending,
  // reset sources and oscillator request
  input  wire logic                 reset_source_req,
  input  wire logic                 lp_osc_off_req,
  // buffered rtc clock in
  input  wire logic                 rtc_buf_clk,
  // port 0 bit 2 clock out
  output logic                      port0_bit2_pin_out,
  output logic                      port0_bit2_pin_oe_n,
  // port 0 bit 3 wake request, open drain
  input  wire logic                 port0_bit3_pin_in,
  output logic                      port0_bit3_pin_out,
  output logic                      port0_bit3_pin_oe_n,
  // power status
  output pmwc_pkg::pmwc_mode_t      power_mode,
  output logic                      power_source_select,
  output logic                      supply_monitor_en,
  output logic                      full_por_req,
  output logic                      lp_osc_enable
);

  // --------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------

  // write strobe for one offset
  function automatic logic wr_hit(input pmwc_pkg::pmwc_bus_t b,
                                  input logic [7:0] ofs);
    wr_hit = b.wr && (b.addr == ofs);
  endfunction

  // read strobe for one offset
  function automatic logic rd_hit(input pmwc_pkg::pmwc_bus_t b,
                                  input logic [7:0] ofs);
    rd_hit = b.rd && (b.addr == ofs);
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------

  logic [7:0]           ctrl_r;        // general flags and power select
  logic [7:0]           mode_r;        // only bits 7..5 are storage
  logic [1:0]           wake_en_r;     // [1] battery, [0] pulse counter
  logic [1:0]           wake_flag_r;   // [1] battery, [0] pulse counter
  logic [1:0]           wake_flag_nxt;
  logic [1:0]           hide_cnt_r;
  logic [1:0]           hide_cnt_nxt;
  logic [7:0]           rdata_nxt;
  pmwc_pkg::pmwc_mode_t mode_state_r;
  pmwc_pkg::pmwc_mode_t mode_state_nxt;

  // --------------------------------------------------------------------
  // event input conditioning
  // --------------------------------------------------------------------

  logic [pmwc_pkg::NUM_EVENTS-1:0] evt_raw;
  logic [pmwc_pkg::NUM_EVENTS-1:0] evt_lvl;
  logic [pmwc_pkg::NUM_EVENTS-1:0] evt_lvl_d_r;
  logic [pmwc_pkg::NUM_EVENTS-1:0] evt_rise;

  assign evt_raw = event_pins;

  // one synchroniser per event pin
  genvar gi;
  generate
    for (gi = 0; gi < pmwc_pkg::NUM_EVENTS; gi++) begin : g_evt_sync
      pmwc_sync3 u_sync (
        .core_clk  (core_clk),
        .reset     (reset),
        .async_in  (evt_raw[gi]),
        .level_out (evt_lvl[gi])
      );
    end
  endgenerate

  // rising edge of each filtered event level
  always_ff @(posedge core_clk) begin
    if (reset) begin
      evt_lvl_d_r <= '0;
    end else begin
      evt_lvl_d_r <= evt_lvl;
    end
  end

  assign evt_rise = evt_lvl & ~evt_lvl_d_r;

  // --------------------------------------------------------------------
  // register write and read decode
  // --------------------------------------------------------------------

  wire wr_ctrl  = wr_hit(bus_req, pmwc_pkg::OFS_POWER_CONTROL);
  wire wr_mode  = wr_hit(bus_req, pmwc_pkg::OFS_POWER_UNIT_MODE);
  wire wr_cfg   = wr_hit(bus_req, pmwc_pkg::OFS_WAKE_CONFIG_1ST);
  wire wr_flag  = wr_hit(bus_req, pmwc_pkg::OFS_WAKE_FLAG_2ND);
  wire rd_ctrl  = rd_hit(bus_req, pmwc_pkg::OFS_POWER_CONTROL);
  wire rd_mode  = rd_hit(bus_req, pmwc_pkg::OFS_POWER_UNIT_MODE);
  wire rd_flag  = rd_hit(bus_req, pmwc_pkg::OFS_WAKE_FLAG_2ND);

  // command bits carried by the write data
  // clear all flags
  wire cmd_clear   = wr_cfg  && bus_req.wdata[pmwc_pkg::BIT_CFG_CLEAR];
  wire cmd_suspend = wr_cfg  && bus_req.wdata[pmwc_pkg::BIT_CFG_SUSPEND];
  wire cmd_sleep   = wr_cfg  && bus_req.wdata[pmwc_pkg::BIT_CFG_SLEEP];
  wire cmd_stop    = wr_ctrl && bus_req.wdata[pmwc_pkg::BIT_STOP];
  wire cmd_idle    = wr_ctrl && bus_req.wdata[pmwc_pkg::BIT_IDLE];

  // --------------------------------------------------------------------
  // wake flags
  // --------------------------------------------------------------------

  // events mapped onto flag order: [1] battery monitor, [0] pulse counter
  wire [1:0] flag_evt = {evt_rise[1], evt_rise[0]};

  // sticky until cleared
  // an event in the clearing cycle survives the clear
  assign wake_flag_nxt = (cmd_clear ? 2'h0 : wake_flag_r) | flag_evt;

  wire any_flag = |wake_flag_r;

  wire own_wake = |(flag_evt & wake_en_r);
  wire wake_hit = own_wake || evt_rise[2] || reset_pin_wake;

  // --------------------------------------------------------------------
  // power mode sequencing
  // --------------------------------------------------------------------

  // refuse low power entry with flags set
  wire lp_entry_ok = !any_flag;

  always_comb begin
    mode_state_nxt = mode_state_r;
    case (mode_state_r)
      pmwc_pkg::PM_RUN: begin
        if (cmd_sleep && lp_entry_ok) begin
          mode_state_nxt = pmwc_pkg::PM_SLEEP;
        end else if (cmd_suspend && lp_entry_ok) begin
          mode_state_nxt = pmwc_pkg::PM_SUSPEND;
        end else if (cmd_stop) begin
          mode_state_nxt = pmwc_pkg::PM_STOP;
        end else if (cmd_idle) begin
          mode_state_nxt = pmwc_pkg::PM_IDLE;
        end
      end
      pmwc_pkg::PM_IDLE: begin
        if (irq_pending) begin
          mode_state_nxt = pmwc_pkg::PM_RUN;
        end
      end
      pmwc_pkg::PM_STOP: begin
        // only a device reset leaves stop
        mode_state_nxt = pmwc_pkg::PM_STOP;
      end
      pmwc_pkg::PM_SUSPEND,
      pmwc_pkg::PM_SLEEP: begin
        if (wake_hit) begin
          mode_state_nxt = pmwc_pkg::PM_RUN;
        end
      end
      default: begin
        mode_state_nxt = pmwc_pkg::PM_RUN;
      end
    endcase
  end

  wire leave_suspend = (mode_state_r == pmwc_pkg::PM_SUSPEND) &&
                       (mode_state_nxt == pmwc_pkg::PM_RUN);
  wire leave_sleep   = (mode_state_r == pmwc_pkg::PM_SLEEP) &&
                       (mode_state_nxt == pmwc_pkg::PM_RUN);

  // hide flags for two clocks after suspend
  always_comb begin
    hide_cnt_nxt = hide_cnt_r;
    if (leave_suspend) begin
      hide_cnt_nxt = 2'(pmwc_pkg::FLAG_HIDE_CLOCKS);
    end else if (hide_cnt_r != 2'h0) begin
      hide_cnt_nxt = hide_cnt_r - 2'h1;
    end
  end

  wire flags_hidden = (hide_cnt_r != 2'h0);

  // --------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------

  // power control: stop and idle never stored
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_r <= pmwc_pkg::RST_POWER_CONTROL;
    end else if (wr_ctrl) begin
      ctrl_r <= {bus_req.wdata[pmwc_pkg::BIT_GF_HI:pmwc_pkg::BIT_POWER_SOURCE_SEL],
                 2'h0};
    end
  end

  // power unit mode: low bits never stored
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_r <= pmwc_pkg::RST_POWER_UNIT_MODE;
    end else if (wr_mode) begin
      mode_r <= {bus_req.wdata[7:5], 5'h00};
    end
  end

  // wake enables, written through the flag register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wake_en_r <= pmwc_pkg::RST_WAKE_ENABLES;
    end else if (wr_flag) begin
      wake_en_r <= {bus_req.wdata[pmwc_pkg::BIT_BATTERY_MON_WAKE],
                    bus_req.wdata[pmwc_pkg::BIT_PULSE_COUNT_WAKE]};
    end
  end

  // flags, hide counter and mode state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wake_flag_r  <= pmwc_pkg::RST_WAKE_FLAGS;
      hide_cnt_r   <= 2'h0;
      mode_state_r <= pmwc_pkg::PM_RUN;
    end else begin
      wake_flag_r  <= wake_flag_nxt;
      hide_cnt_r   <= hide_cnt_nxt;
      mode_state_r <= mode_state_nxt;
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------

  wire [1:0] flag_view = flags_hidden ? 2'h0 : wake_flag_r;

  // read mux; unmapped and command-only offsets read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_ctrl) begin
      rdata_nxt = ctrl_r;
    end else if (rd_mode) begin
      rdata_nxt = mode_r;
    end else if (rd_flag) begin
      rdata_nxt[pmwc_pkg::BIT_BATTERY_MON_WAKE] = flag_view[1];
      rdata_nxt[pmwc_pkg::BIT_PULSE_COUNT_WAKE] = flag_view[0];
    end
  end

  // read data valid one cycle after the strobe only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------------
  // wake request pin
  // --------------------------------------------------------------------

  wire wake_req_en = mode_r[pmwc_pkg::BIT_WAKE_REQ_OUT_EN];
  wire wake_req_active;

  pmwc_req_pulse u_wake_req (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (leave_sleep && wake_req_en),
    .active   (wake_req_active)
  );

  // open drain drive only when enabled
  assign port0_bit3_pin_out  = 1'b0;
  assign port0_bit3_pin_oe_n = !(wake_req_active && wake_req_en);

  // --------------------------------------------------------------------
  // rtc clock output pin
  // --------------------------------------------------------------------

  wire rtc_out_en = mode_r[pmwc_pkg::BIT_RTC_CLOCK_OUT_EN];

  // gate buffered clock onto the pin
  assign port0_bit2_pin_out  = rtc_buf_clk && rtc_out_en;
  assign port0_bit2_pin_oe_n = !rtc_out_en;

  // --------------------------------------------------------------------
  // supply, oscillator and status outputs
  // --------------------------------------------------------------------

  wire monitor_off = mode_r[pmwc_pkg::BIT_SUPPLY_MONITOR_OFF];

  assign supply_monitor_en   = !monitor_off;
  // any reset source escalates while monitor off
  assign full_por_req        = reset_source_req && monitor_off;
  assign lp_osc_enable       = !lp_osc_off_req || any_flag;
  assign power_source_select = ctrl_r[pmwc_pkg::BIT_POWER_SOURCE_SEL];
  assign power_mode          = mode_state_r;

  // wake request pin is only driven here, its sampled level is unused
  wire unused_pin_in = port0_bit3_pin_in;

endmodule // pmwc_power_ctrl

// *** pmwc_pkg.sv ***
// ----------------------------------------------------------------------
// power mode and wake control definitions
// ----------------------------------------------------------------------
package pmwc_pkg;

  // register offsets
  localparam logic [7:0] OFS_POWER_CONTROL    = 8'h87;
  localparam logic [7:0] OFS_POWER_UNIT_MODE  = 8'hb3;
  localparam logic [7:0] OFS_WAKE_CONFIG_1ST  = 8'hb5;
  localparam logic [7:0] OFS_WAKE_FLAG_2ND    = 8'hb6;

  // wake_flag_second fields
  localparam int BIT_PULSE_COUNT_WAKE   = 0;
  localparam int BIT_BATTERY_MON_WAKE   = 2;
  // wake_config_first fields
  localparam int BIT_CFG_CLEAR          = 5;
  localparam int BIT_CFG_SUSPEND        = 6;
  localparam int BIT_CFG_SLEEP          = 7;
  // power_unit_mode fields
  localparam int BIT_SUPPLY_MONITOR_OFF = 5;
  localparam int BIT_WAKE_REQ_OUT_EN    = 6;
  localparam int BIT_RTC_CLOCK_OUT_EN   = 7;
  // power_control fields
  localparam int BIT_IDLE               = 0;
  localparam int BIT_STOP               = 1;
  localparam int BIT_POWER_SOURCE_SEL   = 2;
  localparam int BIT_GF_LO              = 3;
  localparam int BIT_GF_HI              = 7;

  // reset values
  localparam logic [7:0] RST_POWER_CONTROL   = 8'h00;
  localparam logic [7:0] RST_POWER_UNIT_MODE = 8'h00;
  localparam logic [1:0] RST_WAKE_ENABLES    = 2'h0;
  localparam logic [1:0] RST_WAKE_FLAGS      = 2'h0;

  // timing
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int FLAG_HIDE_CLOCKS = 2;
  localparam int WAKE_REQ_NS      = 1000;
  localparam int WAKE_REQ_CYCLES  = (WAKE_REQ_NS * 1000) / CLK_PERIOD_PS;
  localparam int NUM_EVENTS       = 3;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pmwc_bus_t;

  // wake event sources, each a pin level
  typedef struct packed {
    logic other_wake;
    logic battery_monitor;
    logic pulse_count;
  } pmwc_events_t;

  // power modes
  typedef enum logic [2:0] {
    PM_RUN,
    PM_IDLE,
    PM_STOP,
    PM_SUSPEND,
    PM_SLEEP
  } pmwc_mode_t;

endpackage

// *** pmwc_sync3.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// three stage input synchroniser with agreement filter
// ----------------------------------------------------------------------
module pmwc_sync3 (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // asynchronous level in, filtered level out
  input  wire logic async_in,
  output logic      level_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // shift chain; output follows once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_r      <= 1'b0;
      s2_r      <= 1'b0;
      s3_r      <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end

endmodule // pmwc_sync3

// *** pmwc_req_pulse.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// fixed length request pulse
// ----------------------------------------------------------------------
module pmwc_req_pulse (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // start strobe and stretched pulse
  input  wire logic start,
  output logic      active
);

  localparam logic [15:0] LEN = 16'(pmwc_pkg::WAKE_REQ_CYCLES);

  logic [15:0] cnt_r;

  // load on start, count down to zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= 16'h0000;
    end else if (start) begin
      cnt_r <= LEN;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  assign active = (cnt_r != 16'h0000);

endmodule // pmwc_req_pulse

// *** pmwc_power_ctrl_assertions.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// port level checks of the power control block
// ----------------------------------------------------------------------
module pmwc_power_ctrl_chk (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   reset,
  // register port
  input wire pmwc_pkg::pmwc_bus_t    bus_req,
  input wire logic [7:0]             bus_rdata,
  // event and request inputs
  input wire pmwc_pkg::pmwc_events_t event_pins,
  input wire logic                   reset_pin_wake,
  input wire logic                   irq_pending,
  input wire logic                   reset_source_req,
  input wire logic                   lp_osc_off_req,
  input wire logic                   rtc_buf_clk,
  // port pins
  input wire logic                   port0_bit2_pin_out,
  input wire logic                   port0_bit2_pin_oe_n,
  input wire logic                   port0_bit3_pin_in,
  input wire logic                   port0_bit3_pin_out,
  input wire logic                   port0_bit3_pin_oe_n,
  // power status
  input wire pmwc_pkg::pmwc_mode_t   power_mode,
  input wire logic                   power_source_select,
  input wire logic                   supply_monitor_en,
  input wire logic                   full_por_req,
  input wire logic                   lp_osc_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // decoded bus requests
  wire rd_mode = bus_req.rd && bus_req.addr == pmwc_pkg::OFS_POWER_UNIT_MODE;
  wire rd_flag = bus_req.rd && bus_req.addr == pmwc_pkg::OFS_WAKE_FLAG_2ND;
  wire wr_ctrl = bus_req.wr && bus_req.addr == pmwc_pkg::OFS_POWER_CONTROL;
  wire wr_mode = bus_req.wr && bus_req.addr == pmwc_pkg::OFS_POWER_UNIT_MODE;
  wire in_run  = power_mode == pmwc_pkg::PM_RUN;

  chk_rtc_out_off: assert property (port0_bit2_pin_oe_n |-> !port0_bit2_pin_out)
    else $error("clock output active while disabled");
  chk_por_follow: assert property (full_por_req == (reset_source_req && !supply_monitor_en))
    else $error("full reset request wrong");
  chk_osc_kept: assert property (!lp_osc_off_req |-> lp_osc_enable)
    else $error("oscillator stopped without request");
  chk_osc_flagged: assert property (rd_flag ##1 (bus_rdata[2] || bus_rdata[0]) |-> lp_osc_enable)
    else $error("oscillator stopped with a flag set");
  chk_mode_low_zero: assert property (rd_mode |=> bus_rdata[4:0] == 5'h00)
    else $error("mode low bits not zero");
  chk_flag_unused: assert property (rd_flag |=> bus_rdata[7:3] == 5'h00 && !bus_rdata[1])
    else $error("flag register unused bits set");
  chk_rdata_quiet: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data without read");
  chk_select_write: assert property (wr_ctrl |=> power_source_select == $past(bus_req.wdata[2]))
    else $error("power select not written");
  chk_monitor_write: assert property (wr_mode |=> supply_monitor_en != $past(bus_req.wdata[5]))
    else $error("monitor disable not written");
  chk_idle_entry: assert property (
    wr_ctrl && bus_req.wdata[1:0] == 2'h1 && in_run |=> power_mode == pmwc_pkg::PM_IDLE)
    else $error("idle not entered");
  chk_stop_entry: assert property (
    wr_ctrl && bus_req.wdata[1] && in_run |=> power_mode == pmwc_pkg::PM_STOP)
    else $error("stop not entered");
  chk_wake_req_src: assert property (
    $fell(port0_bit3_pin_oe_n) |-> (power_mode != pmwc_pkg::PM_SLEEP)
    && ($past(power_mode) == pmwc_pkg::PM_SLEEP || $past(power_mode, 2) == pmwc_pkg::PM_SLEEP))
    else $error("wake request without sleep exit");
endmodule // pmwc_power_ctrl_chk

bind pmwc_power_ctrl pmwc_power_ctrl_chk u_chk (.core_clk, .reset, .bus_req, .bus_rdata,
  .event_pins, .reset_pin_wake, .irq_pending, .reset_source_req, .lp_osc_off_req,
  .rtc_buf_clk, .port0_bit2_pin_out, .port0_bit2_pin_oe_n, .port0_bit3_pin_in,
  .port0_bit3_pin_out, .port0_bit3_pin_oe_n, .power_mode, .power_source_select,
  .supply_monitor_en, .full_por_req, .lp_osc_enable);

// *** power_mode_wake_control_tb.sv ***
`timescale 1ns/1ps
module power_mode_wake_control_tb;
  // stimulus and observed signals
  logic                   core_clk, reset, irq_pending, reset_source_req, pin_wake;
  logic                   lp_osc_off_req, rtc_buf_clk, pin3_in, p2_out, p2_oe_n;
  logic                   p3_out, p3_oe_n, pwr_sel, mon_en, por_req, osc_en;
  logic [7:0]             bus_rdata;
  pmwc_pkg::pmwc_bus_t    bus_req;
  pmwc_pkg::pmwc_events_t event_pins;
  pmwc_pkg::pmwc_mode_t   power_mode;
  int                     err_count, checked, n;

  pmwc_power_ctrl DUT (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .event_pins(event_pins), .reset_pin_wake(pin_wake),
    .irq_pending(irq_pending), .reset_source_req(reset_source_req),
    .lp_osc_off_req(lp_osc_off_req), .rtc_buf_clk(rtc_buf_clk),
    .port0_bit2_pin_out(p2_out), .port0_bit2_pin_oe_n(p2_oe_n),
    .port0_bit3_pin_in(pin3_in), .port0_bit3_pin_out(p3_out),
    .port0_bit3_pin_oe_n(p3_oe_n), .power_mode(power_mode),
    .power_source_select(pwr_sel), .supply_monitor_en(mon_en),
    .full_por_req(por_req), .lp_osc_enable(osc_en));

  // open drain wake line with pull-up
  assign pin3_in = p3_oe_n ? 1'b1 : p3_out;

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // stand-in for the buffered rtc clock
  always @(posedge core_clk) rtc_buf_clk <= ~rtc_buf_clk;

  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) bus_req.wr <= 1'b0;
    #1;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) bus_req.rd <= 1'b0;
    #1 chk($sformatf("read %h", a), e, bus_rdata);
  endtask

  task mode_is(input pmwc_pkg::pmwc_mode_t e);
    chk("power_mode", 8'(e), 8'(power_mode));
  endtask

  task do_reset;
    @(posedge core_clk) reset <= 1'b1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
  endtask

  // pulse one event pin long enough to pass the synchroniser
  task ev(input bit batt);
    @(posedge core_clk) if (batt) event_pins.battery_monitor <= 1'b1;
    else event_pins.pulse_count <= 1'b1;
    repeat (8) @(posedge core_clk);
    event_pins <= '0;
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  task t_reset_values;
    rd(pmwc_pkg::OFS_POWER_CONTROL, 8'h00);
    rd(pmwc_pkg::OFS_POWER_UNIT_MODE, 8'h00);
    rd(pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h00);
    rd(pmwc_pkg::OFS_WAKE_CONFIG_1ST, 8'h00);
    rd(8'h10, 8'h00);
    chk("oe_n pins", 8'h03, {6'h0, p2_oe_n, p3_oe_n});
    chk("monitor en", 8'h01, {7'h0, mon_en});
    mode_is(pmwc_pkg::PM_RUN);
    $display("test reset values done");
  endtask

  task t_mode_reg;
    wr(pmwc_pkg::OFS_POWER_UNIT_MODE, 8'hff);
    rd(pmwc_pkg::OFS_POWER_UNIT_MODE, 8'he0);
    chk("clk oe_n", 8'h00, {7'h0, p2_oe_n});
    for (n = 0; n < 2; n++) begin
      @(posedge core_clk) #1 chk("clk out", {7'h0, rtc_buf_clk}, {7'h0, p2_out});
    end
    chk("monitor en", 8'h00, {7'h0, mon_en});
    @(posedge core_clk) reset_source_req <= 1'b1;
    @(posedge core_clk) #1 chk("full por", 8'h01, {7'h0, por_req});
    @(posedge core_clk) reset_source_req <= 1'b0;
    wr(pmwc_pkg::OFS_POWER_UNIT_MODE, 8'h00);
    chk("clk off", 8'h02, {6'h0, p2_oe_n, p2_out});
    chk("monitor on", 8'h01, {7'h0, mon_en});
    $display("test mode register done");
  endtask

  task t_control;
    wr(pmwc_pkg::OFS_POWER_CONTROL, 8'hfc);
    rd(pmwc_pkg::OFS_POWER_CONTROL, 8'hfc);
    chk("power select", 8'h01, {7'h0, pwr_sel});
    wr(pmwc_pkg::OFS_POWER_CONTROL, 8'h01);
    mode_is(pmwc_pkg::PM_IDLE);
    rd(pmwc_pkg::OFS_POWER_CONTROL, 8'h00);
    @(posedge core_clk) irq_pending <= 1'b1;
    @(posedge core_clk) irq_pending <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 mode_is(pmwc_pkg::PM_RUN);
    wr(pmwc_pkg::OFS_POWER_CONTROL, 8'h02);
    mode_is(pmwc_pkg::PM_STOP);
    do_reset();
    #1 mode_is(pmwc_pkg::PM_RUN);
    $display("test control register done");
  endtask

  task t_flags;
    @(posedge core_clk) lp_osc_off_req <= 1'b1;
    ev(1'b0);
    rd(pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h01);
    chk("osc enable", 8'h01, {7'h0, osc_en});
    ev(1'b1);
    rd(pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h05);
    rd(pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h05);
    wr(pmwc_pkg::OFS_WAKE_CONFIG_1ST, 8'h40);
    mode_is(pmwc_pkg::PM_RUN);
    wr(pmwc_pkg::OFS_WAKE_CONFIG_1ST, 8'h20);
    rd(pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h00);
    chk("osc disabled", 8'h00, {7'h0, osc_en});
    @(posedge core_clk) lp_osc_off_req <= 1'b0;
    $display("test flags done");
  endtask

  task t_sleep_wake;
    wr(pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h01);
    wr(pmwc_pkg::OFS_POWER_UNIT_MODE, 8'h40);
    wr(pmwc_pkg::OFS_WAKE_CONFIG_1ST, 8'h80);
    mode_is(pmwc_pkg::PM_SLEEP);
    ev(1'b1);
    mode_is(pmwc_pkg::PM_SLEEP);
    @(posedge core_clk) event_pins.pulse_count <= 1'b1;
    n = 0;
    while (p3_oe_n !== 1'b0 && n < 20) begin
      @(posedge core_clk) #1 n++;
    end
    mode_is(pmwc_pkg::PM_RUN);
    chk("wake line", 8'h00, {7'h0, pin3_in});
    n = 0;
    while (p3_oe_n === 1'b0 && n < 400) begin
      @(posedge core_clk) #1 n++;
    end
    chk("wake length", 8'(pmwc_pkg::WAKE_REQ_CYCLES), 8'(n));
    @(posedge core_clk) event_pins <= '0;
    rd(pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h05);
    wr(pmwc_pkg::OFS_WAKE_CONFIG_1ST, 8'h20);
    $display("test sleep wake done");
  endtask

  task t_suspend;
    wr(pmwc_pkg::OFS_POWER_UNIT_MODE, 8'h00);
    wr(pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h01);
    wr(pmwc_pkg::OFS_WAKE_CONFIG_1ST, 8'h40);
    mode_is(pmwc_pkg::PM_SUSPEND);
    @(posedge core_clk) bus_req <= '{pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h00, 1'b0, 1'b1};
    event_pins.pulse_count <= 1'b1;
    n = 0;
    while (power_mode !== pmwc_pkg::PM_RUN && n < 20) begin
      @(posedge core_clk) #1 n++;
    end
    @(posedge core_clk) #1 chk("hidden flag 1", 8'h00, bus_rdata);
    @(posedge core_clk) bus_req.rd <= 1'b0;
    #1 chk("hidden flag 2", 8'h00, bus_rdata);
    @(posedge core_clk) event_pins <= '0;
    rd(pmwc_pkg::OFS_WAKE_FLAG_2ND, 8'h01);
    wr(pmwc_pkg::OFS_WAKE_CONFIG_1ST, 8'h20);
    wr(pmwc_pkg::OFS_WAKE_CONFIG_1ST, 8'h80);
    mode_is(pmwc_pkg::PM_SLEEP);
    @(posedge core_clk) pin_wake <= 1'b1;
    @(posedge core_clk) pin_wake <= 1'b0;
    #1 mode_is(pmwc_pkg::PM_RUN);
    chk("wake line off", 8'h01, {7'h0, p3_oe_n});
    $display("test suspend wake done");
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial begin
    {reset, irq_pending, reset_source_req, lp_osc_off_req, rtc_buf_clk, pin_wake} = 6'h20;
    bus_req = '0;
    event_pins = '0;
    err_count = 0;
    checked = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_values();
    t_mode_reg();
    t_control();
    t_flags();
    t_sleep_wake();
    t_suspend();
    test_done();
  end

  // watchdog against a hang
  initial begin
    repeat (6000) @(posedge core_clk);
    err_count++;
    test_done();
  end
endmodule // power_mode_wake_control_tb
